// file: dsp_defs.svh
/*
 Constants of the display host serial port: address prefix, control byte
 fields, bit slots and the display RAM address map for each mode.
 Assumes nothing; included by every file of the block that needs a value.
*/
`ifndef DSP_DEFS_SVH
`define DSP_DEFS_SVH

`define DSP_SLAVE_PREFIX  6'h1D
`define DSP_RS_RAM        2'h1
`define DSP_CO_BIT        7
`define DSP_RS_HI         6
`define DSP_RS_LO         5
`define DSP_PFX_HI        7
`define DSP_PFX_LO        2
`define DSP_STRAP_BIT     1
`define DSP_RW_BIT        0
`define DSP_BIT_LAST      4'h7
`define DSP_BIT_ACK       4'h8
`define DSP_HOME          7'h00
`define DSP_LINE1_END     7'h27
`define DSP_LINE2_START   7'h40
`define DSP_LINE2_END     7'h67
`define DSP_FULL_END      7'h4F
`define DSP_RAM_DEPTH     7'h50
`define DSP_IDX_LINE2     7'h28
`define DSP_SPAN_WIDE     8'h50
`define DSP_SPAN_NARROW   8'h28

`endif

// file: dsp_types_pkg.sv
/*
 Types shared by the display host serial port: display modes, transfer
 phases and the command byte carrier.
 Assumes the constants header is compiled alongside.
*/
package dsp_types_pkg;

	typedef enum logic [1:0] {
		MODE_1X40,
		MODE_2X20,
		MODE_1X20
	} disp_mode_t;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_ADDR,
		PH_CTRL,
		PH_DATA,
		PH_READ,
		PH_IGNORE
	} phase_t;

	typedef struct packed {
		logic       valid;
		logic [1:0] page;
		logic [7:0] data;
	} cmd_t;

endpackage

// file: serial_bit_capture.sv
/*
 Link side bit capture: shifts the serial data input in on each rising
 edge of the serial clock.
 Assumes the serial clock only pulses during frames; the word is read by
 the system domain after a synchronised rising edge, when it is stable.
*/
`timescale 1ns/1ps
module serial_bit_capture (
	input  logic       i_scl,
	input  logic       i_sda,
	output logic [7:0] o_word
);

	// No reset: the link clock may stand still, and framing lives elsewhere
	always_ff @(posedge i_scl) begin
		o_word <= {o_word[6:0], i_sda};
	end

endmodule

// file: display_ram_store.sv
/*
 Display data RAM: 80 character codes in flip-flops, one write port and
 two combinational read ports (host and display scan).
 Assumes addresses come from the display address map of the current mode.
*/
`timescale 1ns/1ps
`include "dsp_defs.svh"
module display_ram_store (
	input  logic                    i_clk,
	input  dsp_types_pkg::disp_mode_t i_mode,
	input  logic                    i_we,
	input  logic [6:0]              i_waddr,
	input  logic [7:0]              i_wdata,
	input  logic [6:0]              i_raddr,
	output logic [7:0]              o_rdata,
	input  logic [6:0]              i_saddr,
	output logic [7:0]              o_sdata
);

	logic [7:0] mem [0:`DSP_RAM_DEPTH-1];
	logic [6:0] widx;
	logic [6:0] ridx;
	logic [6:0] sidx;

	// Second line of the two line mode folds onto the upper forty cells
	function automatic logic [6:0] ram_index(input logic [6:0] a,
			input dsp_types_pkg::disp_mode_t m);
		if (m == dsp_types_pkg::MODE_2X20 && a[6])
			ram_index = 7'(`DSP_IDX_LINE2 + {1'b0, a[5:0]});
		else
			ram_index = a;
	endfunction

	assign widx = ram_index(i_waddr, i_mode);
	assign ridx = ram_index(i_raddr, i_mode);
	assign sidx = ram_index(i_saddr, i_mode);

	// Cells outside the shown window stay plain storage
	always_ff @(posedge i_clk) begin
		if (i_we && widx < `DSP_RAM_DEPTH) begin
			mem[widx] <= i_wdata;
		end
	end

	assign o_rdata = (ridx < `DSP_RAM_DEPTH) ? mem[ridx] : 8'h00;
	assign o_sdata = (sidx < `DSP_RAM_DEPTH) ? mem[sidx] : 8'h00;

endmodule

// file: display_host_serial_port.sv
/*
 Host serial port of a character display controller: two wire slave with
 split data input and acknowledge output, control byte steering, display
 RAM, address counter wrap and display scan with cursor position.
 Assumes I_SCL is the link clock from the bus master, the data input and
 the strap are pins, and mode, shift and address load come from commands.
*/
`timescale 1ns/1ps
`include "dsp_defs.svh"
module display_host_serial_port (
	input  logic                      I_CLK,
	input  logic                      I_SYS_RST,
	input  logic                      I_SCL,
	input  logic                      I_SERIAL_DATA_INPUT,
	input  logic                      I_ADDRESS_STRAP_INPUT,
	output logic                      O_ACKNOWLEDGE_OUTPUT,
	output logic                      O_ACKNOWLEDGE_OE,
	input  dsp_types_pkg::disp_mode_t I_MODE,
	input  logic [6:0]                I_SHIFT,
	input  logic                      I_AC_LOAD,
	input  logic [6:0]                I_AC_VALUE,
	output logic [6:0]                O_AC,
	output dsp_types_pkg::cmd_t       O_CMD,
	input  logic                      I_SCAN_LINE,
	input  logic [5:0]                I_SCAN_COL,
	output logic [7:0]                O_SCAN_CODE,
	output logic                      O_CURSOR_HIT,
	output logic                      O_BUSY
);

	logic                  scl_meta, scl_s, scl_d;
	logic                  sda_meta, sda_s, sda_d;
	logic                  strap_meta, strap_s;
	logic                  scl_rise, scl_fall, start_cond, stop_cond;
	logic                  byte_done, ack_rise, addr_match, ram_we;
	logic                  more_ctrl, ack_pending, drive_low, tx_load;
	logic [1:0]            reg_sel;
	logic [3:0]            bit_cnt;
	logic [6:0]            ac, ac_next, scan_base, scan_addr;
	logic [7:0]            link_word, tx, ram_rdata, scan_data;
	logic [7:0]            span, scan_sum, scan_pos;
	dsp_types_pkg::phase_t phase, next_phase;

	// Address after a host access: line one end steps into line two in two line mode; the last address wraps home
	function automatic logic [6:0] next_addr(input logic [6:0] a,
			input dsp_types_pkg::disp_mode_t m);
		case (m)
			dsp_types_pkg::MODE_1X40:
				next_addr = (a == `DSP_FULL_END) ? `DSP_HOME : 7'(a + 7'h01);
			dsp_types_pkg::MODE_2X20:
				if (a == `DSP_LINE1_END)
					next_addr = `DSP_LINE2_START;
				else if (a == `DSP_LINE2_END)
					next_addr = `DSP_HOME;
				else
					next_addr = 7'(a + 7'h01);
			default:
				next_addr = (a == `DSP_LINE1_END) ? `DSP_HOME : 7'(a + 7'h01);
		endcase
	endfunction

	function automatic logic in_space(input logic [6:0] a,
			input dsp_types_pkg::disp_mode_t m);
		case (m)
			dsp_types_pkg::MODE_1X40:
				in_space = (a <= `DSP_FULL_END);
			dsp_types_pkg::MODE_2X20:
				in_space = (a <= `DSP_LINE1_END) ||
					(a >= `DSP_LINE2_START && a <= `DSP_LINE2_END);
			default:
				in_space = (a <= `DSP_LINE1_END);
		endcase
	endfunction

	// Pins cross into the system clock; edges use the second and third flops, never the first
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			scl_meta <= 1'b1;
			scl_s    <= 1'b1;
			scl_d    <= 1'b1;
			sda_meta <= 1'b1;
			sda_s    <= 1'b1;
			sda_d    <= 1'b1;
		end else begin
			scl_meta <= I_SCL;
			scl_s    <= scl_meta;
			scl_d    <= scl_s;
			sda_meta <= I_SERIAL_DATA_INPUT;
			sda_s    <= sda_meta;
			sda_d    <= sda_s;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			strap_meta <= 1'b0;
			strap_s    <= 1'b0;
		end else begin
			strap_meta <= I_ADDRESS_STRAP_INPUT;
			strap_s    <= strap_meta;
		end
	end

	assign scl_rise   = scl_s & ~scl_d;
	assign scl_fall   = ~scl_s & scl_d;
	assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

	// Word is stable for a whole clock low phase after the synced rise
	serial_bit_capture u_capture (
		.i_scl  (I_SCL),
		.i_sda  (I_SERIAL_DATA_INPUT),
		.o_word (link_word)
	);

	// Eight data slots then one acknowledge slot, repeated without limit
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST || start_cond || phase == dsp_types_pkg::PH_IDLE) begin
			bit_cnt <= 4'h0;
		end else if (scl_rise) begin
			bit_cnt <= (bit_cnt == `DSP_BIT_ACK) ? 4'h0 : 4'(bit_cnt + 4'h1);
		end
	end

	assign byte_done = scl_rise && bit_cnt == `DSP_BIT_LAST;
	assign ack_rise  = scl_rise && bit_cnt == `DSP_BIT_ACK;

	assign addr_match = link_word[`DSP_PFX_HI:`DSP_PFX_LO] == `DSP_SLAVE_PREFIX &&
		link_word[`DSP_STRAP_BIT] == strap_s;

	always_comb begin
		next_phase = phase;
		if (stop_cond) begin
			next_phase = dsp_types_pkg::PH_IDLE;
		end else if (start_cond) begin
			next_phase = dsp_types_pkg::PH_ADDR;
		end else begin
			case (phase)
				dsp_types_pkg::PH_ADDR:
					if (byte_done) begin
						if (!addr_match)
							next_phase = dsp_types_pkg::PH_IGNORE;
						else if (link_word[`DSP_RW_BIT])
							next_phase = dsp_types_pkg::PH_READ;
						else
							next_phase = dsp_types_pkg::PH_CTRL;
					end
				dsp_types_pkg::PH_CTRL:
					if (byte_done)
						next_phase = dsp_types_pkg::PH_DATA;
				dsp_types_pkg::PH_DATA:
					if (byte_done && more_ctrl)
						next_phase = dsp_types_pkg::PH_CTRL;
				dsp_types_pkg::PH_READ:
					if (ack_rise && sda_s && !ack_pending)
						next_phase = dsp_types_pkg::PH_IGNORE;
				default:
					next_phase = phase;
			endcase
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST)
			phase <= dsp_types_pkg::PH_IDLE;
		else
			phase <= next_phase;
	end

	// Control byte: continuation flag and register select, low bits unused
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST || start_cond) begin
			more_ctrl <= 1'b0;
			reg_sel   <= 2'h0;
		end else if (phase == dsp_types_pkg::PH_CTRL && byte_done) begin
			more_ctrl <= link_word[`DSP_CO_BIT];
			reg_sel   <= link_word[`DSP_RS_HI:`DSP_RS_LO];
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST || start_cond || stop_cond) begin
			ack_pending <= 1'b0;
		end else if (byte_done) begin
			ack_pending <= (phase == dsp_types_pkg::PH_ADDR && addr_match) ||
				phase == dsp_types_pkg::PH_CTRL ||
				phase == dsp_types_pkg::PH_DATA;
		end else if (ack_rise) begin
			ack_pending <= 1'b0;
		end
	end

	// Writes outside the mode's space are dropped rather than aliased
	assign ram_we = phase == dsp_types_pkg::PH_DATA && byte_done &&
		reg_sel == `DSP_RS_RAM && in_space(ac, I_MODE);

	// The address's own ack slot is ours, not a master acknowledge
	assign tx_load = (phase == dsp_types_pkg::PH_ADDR && byte_done &&
		addr_match && link_word[`DSP_RW_BIT]) ||
		(phase == dsp_types_pkg::PH_READ && ack_rise && !sda_s &&
		!ack_pending);

	assign ac_next = next_addr(ac, I_MODE);

	// Outside load wins over a host access landing in the same cycle
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST)
			ac <= `DSP_HOME;
		else if (I_AC_LOAD)
			ac <= I_AC_VALUE;
		else if (ram_we || tx_load)
			ac <= ac_next;
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_CMD <= '0;
		end else begin
			O_CMD.valid <= phase == dsp_types_pkg::PH_DATA && byte_done &&
				reg_sel != `DSP_RS_RAM;
			O_CMD.page  <= reg_sel;
			O_CMD.data  <= link_word;
		end
	end

	display_ram_store u_ram (
		.i_clk   (I_CLK),
		.i_mode  (I_MODE),
		.i_we    (ram_we),
		.i_waddr (ac),
		.i_wdata (link_word),
		.i_raddr (ac),
		.o_rdata (ram_rdata),
		.i_saddr (scan_addr),
		.o_sdata (scan_data)
	);

	// Line drive changes after a synced fall or is released at start and stop, so data holds while high within a byte
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST || start_cond || stop_cond) begin
			drive_low <= 1'b0;
			tx        <= 8'h00;
		end else begin
			if (tx_load)
				tx <= ram_rdata;
			if (scl_fall) begin
				if (bit_cnt == `DSP_BIT_ACK) begin
					drive_low <= ack_pending;
				end else if (phase == dsp_types_pkg::PH_READ) begin
					drive_low <= ~tx[7];
					tx        <= {tx[6:0], 1'b0};
				end else begin
					drive_low <= 1'b0;
				end
			end
		end
	end

	// Open drain: only ever pulls low, never the clock
	assign O_ACKNOWLEDGE_OUTPUT = 1'b0;
	assign O_ACKNOWLEDGE_OE     = drive_low;
	assign O_AC                 = ac;
	assign O_BUSY               = phase != dsp_types_pkg::PH_IDLE;

	// Scan: shift is taken below one line span; a larger shift aliases
	assign span = (I_MODE == dsp_types_pkg::MODE_1X40) ?
		`DSP_SPAN_WIDE : `DSP_SPAN_NARROW;
	assign scan_sum  = 8'({2'h0, I_SCAN_COL} + {1'b0, I_SHIFT});
	assign scan_pos  = (scan_sum >= span) ? 8'(scan_sum - span) : scan_sum;
	assign scan_base = (I_MODE == dsp_types_pkg::MODE_2X20 && I_SCAN_LINE) ?
		`DSP_LINE2_START : `DSP_HOME;
	assign scan_addr = 7'(scan_base + scan_pos[6:0]);

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_SCAN_CODE  <= 8'h00;
			O_CURSOR_HIT <= 1'b0;
		end else begin
			O_SCAN_CODE  <= scan_data;
			O_CURSOR_HIT <= scan_addr == ac;
		end
	end

	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);

	sequence s_write_addr;
		phase == dsp_types_pkg::PH_ADDR && byte_done && addr_match &&
			!link_word[`DSP_RW_BIT] && !stop_cond && !start_cond;
	endsequence
	sequence s_ctrl_byte;
		phase == dsp_types_pkg::PH_CTRL && byte_done && !stop_cond &&
			!start_cond;
	endsequence
	sequence s_read_nack;
		phase == dsp_types_pkg::PH_READ && ack_rise && sda_s &&
			!ack_pending && !stop_cond && !start_cond;
	endsequence

	a_reset_idle_release: assert property (
		$fell(I_SYS_RST) |-> phase == dsp_types_pkg::PH_IDLE && !drive_low)
		else $error("not idle and released after reset");
	a_start_to_addr: assert property (
		start_cond && !stop_cond |=> phase == dsp_types_pkg::PH_ADDR &&
			bit_cnt == 4'h0 && !drive_low)
		else $error("start did not open address phase");
	a_stop_to_idle: assert property (
		stop_cond |=> phase == dsp_types_pkg::PH_IDLE && !drive_low)
		else $error("stop did not end transfer");
	a_ctrl_after_addr: assert property (
		s_write_addr |=> phase == dsp_types_pkg::PH_CTRL && ack_pending)
		else $error("write address not followed by control phase");
	a_cont_flag_steer: assert property (
		s_ctrl_byte |=> phase == dsp_types_pkg::PH_DATA &&
			more_ctrl == $past(link_word[`DSP_CO_BIT]))
		else $error("continuation flag not captured");
	a_foreign_no_ack: assert property (
		phase == dsp_types_pkg::PH_IGNORE && !$past(ack_pending) |->
			!ack_pending && !drive_low)
		else $error("ignored transfer acknowledged");
	a_ack_slot_only: assert property (
		$rose(drive_low) && phase != dsp_types_pkg::PH_READ |->
			bit_cnt == `DSP_BIT_ACK && $past(ack_pending))
		else $error("acknowledge outside its slot");
	a_nack_release: assert property (
		s_read_nack |=> phase == dsp_types_pkg::PH_IGNORE ##1 !drive_low[*3])
		else $error("line not released after missing acknowledge");
	a_ram_or_cmd: assert property (
		ram_we |=> !O_CMD.valid)
		else $error("RAM byte also issued as command");
	a_wrap_two_line: assert property (
		ram_we && !I_AC_LOAD && ac == `DSP_LINE1_END &&
			I_MODE == dsp_types_pkg::MODE_2X20 |=> ac == `DSP_LINE2_START)
		else $error("two line wrap into second line missing");
	a_write_advance: assert property (
		ram_we && !I_AC_LOAD |=> ac == $past(ac_next) && O_AC == ac)
		else $error("address counter did not advance after write");

endmodule

// file: i2c_host_model.sv
/*
 Two wire bus master model: start, stop, byte write and byte read.
 Assumes the bench resolves the pulled-up data wire from all enables.
*/
`timescale 1ns/1ps
module i2c_host_model (
	output logic o_scl,
	input  logic i_sda,
	output logic o_sda_oe
);
	// Quarter bit; slow enough for the two stage sync in the device
	localparam time Q = 25ns;
	initial begin
		o_scl    = 1'b1;
		o_sda_oe = 1'b0;
	end
	// Clock stands high and data released while idle
	task automatic start();
		#Q o_sda_oe = 1'b0;
		#Q o_scl = 1'b1;
		#Q o_sda_oe = 1'b1;
		#Q o_scl = 1'b0;
	endtask
	task automatic stop();
		#Q o_sda_oe = 1'b1;
		#Q o_scl = 1'b1;
		#Q o_sda_oe = 1'b0;
		#Q;
	endtask
	// Data moves only while the clock is low
	task automatic bit_io(input logic b, output logic s);
		#Q o_sda_oe = ~b;
		#Q o_scl = 1'b1;
		#(2*Q) s = i_sda;
		o_scl = 1'b0;
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, s);
	endtask
endmodule

// file: tb.sv
/*
 Self-checking bench of the display host serial port.
 Assumes the bus master model; the data wire has a pull-up.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("[FAIL] %s exp %h got %h", nm, e, g); \
	end \
end
module tb;
	logic                      clk       = 1'b0;
	logic                      rst       = 1'b1;
	logic                      strap     = 1'b1;
	logic                      ack_open  = 1'b0;
	logic                      ac_load   = 1'b0;
	logic                      scan_line = 1'b0;
	logic [6:0]                shift     = 7'h00;
	logic [6:0]                ac_val    = 7'h00;
	logic [5:0]                scan_col  = 6'h00;
	dsp_types_pkg::disp_mode_t mode      = dsp_types_pkg::MODE_1X40;
	logic                      scl;
	logic                      m_oe;
	logic                      sda;
	logic                      ack_out;
	logic                      ack_oe;
	logic                      cursor;
	logic                      busy;
	logic [6:0]                ac;
	logic [7:0]                scode;
	dsp_types_pkg::cmd_t       cmd;
	dsp_types_pkg::cmd_t       cmd_q[$];
	int                        n_errors     = 0;
	int                        total_checks = 0;

	always #2.5 clk = ~clk;
	// Open acknowledge pin: the device's pull never reaches the wire
	assign sda = ~(m_oe | (ack_oe & ~ack_out & ~ack_open));
	always @(posedge clk) begin
		if (cmd.valid === 1'b1) begin
			cmd_q.push_back(cmd);
		end
	end

	i2c_host_model host (.o_scl(scl), .i_sda(sda), .o_sda_oe(m_oe));
	display_host_serial_port dut (
		.I_CLK(clk), .I_SYS_RST(rst), .I_SCL(scl),
		.I_SERIAL_DATA_INPUT(sda), .I_ADDRESS_STRAP_INPUT(strap),
		.O_ACKNOWLEDGE_OUTPUT(ack_out), .O_ACKNOWLEDGE_OE(ack_oe),
		.I_MODE(mode), .I_SHIFT(shift), .I_AC_LOAD(ac_load),
		.I_AC_VALUE(ac_val), .O_AC(ac), .O_CMD(cmd),
		.I_SCAN_LINE(scan_line), .I_SCAN_COL(scan_col),
		.O_SCAN_CODE(scode), .O_CURSOR_HIT(cursor), .O_BUSY(busy)
	);

	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic cfg(input dsp_types_pkg::disp_mode_t m,
			input logic [6:0] s);
		@(posedge clk);
		mode  <= m;
		shift <= s;
	endtask
	task automatic load_ac(input logic [6:0] v);
		@(posedge clk);
		ac_load <= 1'b1;
		ac_val  <= v;
		@(posedge clk);
		ac_load <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic wr_frame(input logic [7:0] q[$]);
		logic a;
		host.start();
		foreach (q[i]) begin
			host.wr_byte(q[i], a);
			`CHK("ack", !ack_open, a)
			`CHK("busy", 1'b1, busy)
		end
		host.stop();
		repeat (8) @(posedge clk);
		`CHK("idle", 1'b0, busy)
	endtask
	task automatic scan(input logic l, input logic [5:0] c);
		@(posedge clk);
		scan_line <= l;
		scan_col  <= c;
		repeat (3) @(posedge clk);
	endtask
	task automatic t_reset();
		`CHK("oe", 1'b0, ack_oe)
		`CHK("ac", 7'h00, ac)
		`CHK("busy", 1'b0, busy)
		`CHK("ackval", 1'b0, ack_out)
	endtask
	task automatic t_ram();
		cfg(dsp_types_pkg::MODE_2X20, 7'h00);
		load_ac(7'h26);
		wr_frame('{8'h76, 8'h20, 8'hA1, 8'hA2, 8'hA3});
		`CHK("ac", 7'h41, ac)
		scan(1'b0, 6'h26);
		`CHK("ram", 8'hA1, scode)
		scan(1'b1, 6'h00);
		`CHK("ram", 8'hA3, scode)
		cfg(dsp_types_pkg::MODE_2X20, 7'h27);
		scan(1'b1, 6'h01);
		`CHK("shift", 8'hA3, scode)
		load_ac(7'h40);
		`CHK("cursor", 1'b1, cursor)
		scan(1'b1, 6'h02);
		`CHK("cursor", 1'b0, cursor)
	endtask
	task automatic t_wrap();
		dsp_types_pkg::disp_mode_t md[3];
		logic [6:0] st[3];
		md = '{dsp_types_pkg::MODE_1X40, dsp_types_pkg::MODE_2X20,
			dsp_types_pkg::MODE_1X20};
		st = '{7'h4F, 7'h67, 7'h27};
		for (int i = 0; i < 3; i++) begin
			cfg(md[i], 7'h00);
			load_ac(st[i]);
			wr_frame('{8'h76, 8'h20, 8'hB0 + 8'(i)});
			`CHK("wrap", 7'h00, ac)
		end
		cfg(dsp_types_pkg::MODE_1X40, 7'h4F);
		scan(1'b0, 6'h28);
		`CHK("shift", 8'hB2, scode)
	endtask
	task automatic t_cmd();
		logic [9:0] ex[5];
		ex = '{{2'h0, 8'h11}, {2'h2, 8'h22}, {2'h3, 8'h33},
			{2'h0, 8'h55}, {2'h0, 8'h66}};
		cfg(dsp_types_pkg::MODE_1X40, 7'h00);
		load_ac(7'h05);
		cmd_q.delete();
		wr_frame('{8'h76, 8'h80, 8'h11, 8'hC0, 8'h22, 8'hE0, 8'h33,
			8'h20, 8'h44});
		wr_frame('{8'h76, 8'h1F, 8'h55, 8'h66});
		`CHK("ncmd", 5, cmd_q.size())
		for (int i = 0; i < 5 && i < cmd_q.size(); i++) begin
			`CHK("cmd", ex[i], {cmd_q[i].page, cmd_q[i].data})
		end
		`CHK("ac", 7'h06, ac)
		scan(1'b0, 6'h05);
		`CHK("ram", 8'h44, scode)
	endtask
	task automatic t_strap();
		logic a;
		cmd_q.delete();
		host.start();
		host.wr_byte(8'h74, a);
		`CHK("nack", 1'b0, a)
		host.wr_byte(8'h00, a);
		host.wr_byte(8'h99, a);
		`CHK("nack", 1'b0, a)
		host.stop();
		repeat (8) @(posedge clk);
		`CHK("ac", 7'h06, ac)
		`CHK("ncmd", 0, cmd_q.size())
	endtask
	task automatic t_read();
		logic a;
		logic [7:0] d;
		load_ac(7'h10);
		wr_frame('{8'h76, 8'h20, 8'h5A, 8'hC3});
		load_ac(7'h10);
		host.start();
		host.wr_byte(8'h77, a);
		`CHK("ack", 1'b1, a)
		host.rd_byte(1'b0, d);
		`CHK("rd", 8'h5A, d)
		host.rd_byte(1'b1, d);
		`CHK("rd", 8'hC3, d)
		repeat (10) @(posedge clk);
		`CHK("rel", 1'b1, sda)
		`CHK("ackval", 1'b0, ack_out)
		host.stop();
		repeat (8) @(posedge clk);
	endtask
	task automatic t_open();
		ack_open <= 1'b1;
		load_ac(7'h30);
		wr_frame('{8'h76, 8'h20, 8'h3C});
		ack_open <= 1'b0;
		`CHK("ac", 7'h31, ac)
		scan(1'b0, 6'h30);
		`CHK("ram", 8'h3C, scode)
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_reset();
		t_ram();
		t_wrap();
		t_cmd();
		t_strap();
		t_read();
		t_open();
		end_sim();
	end
	// About 40 us of traffic expected
	initial begin
		#400us;
		n_errors++;
		end_sim();
	end
endmodule
